/* File: src/mfw_ctrl.sv */
// Flash write/erase sequencer with unlock, power-fail handling and boot select
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/100ps
module mfw_ctrl #(
  parameter int ERASE_CYCLES = mfw_pkg::ERASE_CYC
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic core_wr_i,
  input wire logic [14:0] core_addr_i,
  input wire logic [7:0] core_wdata_i,
  input wire logic core_fetch_flash_i,
  output logic core_stall_o,
  output logic core_irq_hold_o,
  output logic [15:0] core_start_addr_o,
  output logic [15:0] core_vector_base_o,
  input wire logic power_fail_i,
  input wire logic [6:0] unprotected_page_count_i,
  input wire logic data_area_enable_i,
  output logic flash_prog_o,
  output logic flash_erase_o,
  output logic [14:0] flash_addr_o,
  output logic [7:0] flash_wdata_o,
  output logic [14:0] flash_rd_addr_o,
  input wire logic [7:0] flash_rd_data_i
);
  import mfw_pkg::*;

  localparam logic [OP_CNT_W-1:0] WRITE_LAST = OP_CNT_W'(WRITE_CYC - 1);
  localparam logic [OP_CNT_W-1:0] ERASE_LAST = OP_CNT_W'(ERASE_CYCLES - 1);

  // Page may be touched if below the unprotected count, or in the data pair when the data area is enabled
  function automatic logic page_open(input logic [5:0] page, input logic [6:0] unprotected_page_count,
                                     input logic data_area_enable);
    page_open = ({1'b0, page} < unprotected_page_count) || (data_area_enable && page >= DATA_PAGE_FIRST);
  endfunction

  // Power-fail is asynchronous to the clock: two flops before use
  logic pf_meta_reg;
  logic pf_reg;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pf_meta_reg <= 1'b0;
      pf_reg <= 1'b0;
    end else begin
      pf_meta_reg <= power_fail_i;
      pf_reg <= pf_meta_reg;
    end
  end

  // Boot parity scan runs right after reset
  logic scan_done;
  logic scan_odd;

  mfw_top_scan u_scan (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .rd_addr_o(flash_rd_addr_o),
    .rd_data_i(flash_rd_data_i),
    .done_o(scan_done),
    .odd_o(scan_odd)
  );

  // APB decode; the slave always answers in the access cycle
  logic apb_wr;
  logic apb_rd;
  logic hit;

  assign apb_wr = psel_i && penable_i && pwrite_i;
  assign apb_rd = psel_i && penable_i && !pwrite_i;
  assign hit = (paddr_i == ADDR_CMD) || (paddr_i == ADDR_STAT) ||
               (paddr_i == ADDR_PROT) || (paddr_i == ADDR_BOOT);
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !hit;

  logic cmd_wr;
  logic stat_wr;
  logic [7:0] wbyte;

  assign cmd_wr = apb_wr && (paddr_i == ADDR_CMD);
  assign stat_wr = apb_wr && (paddr_i == ADDR_STAT);
  assign wbyte = pwdata_i[7:0];

  // Unlock state, prescaler and 7-bit down counter
  mfw_lock_t lock_reg;
  mfw_lock_t lock_next;
  logic [6:0] dcnt_reg;
  logic [6:0] dcnt_next;
  logic [3:0] tick_reg;
  logic [3:0] tick_next;
  logic wen_reg;
  logic wen_next;
  logic [7:0] cmd_reg;
  logic [7:0] cmd_next;

  // Operation state
  mfw_op_t op_reg;
  mfw_op_t op_next;
  logic [OP_CNT_W-1:0] opcnt_reg;
  logic [OP_CNT_W-1:0] opcnt_next;
  logic [14:0] faddr_reg;
  logic [14:0] faddr_next;
  logic [7:0] fdata_reg;
  logic [7:0] fdata_next;
  logic busy;
  logic erase_go;
  logic write_go;

  assign busy = (op_reg != OP_IDLE);

  // New requests need enable, an idle array, no power fail and an open page
  assign erase_go = cmd_wr && ({1'b0, wbyte} < {1'b0, PAGE_LIMIT}) && wen_reg &&
                    !busy && !pf_reg &&
                    page_open(wbyte[5:0], unprotected_page_count_i, data_area_enable_i);
  assign write_go = core_wr_i && wen_reg && !busy && !pf_reg &&
                    page_open(core_addr_i[14:9], unprotected_page_count_i,
                              data_area_enable_i);

  // Unlock sequence; 15-clock steps of 60 ns keep the window just under 8 us
  always_comb begin
    lock_next = lock_reg;
    dcnt_next = dcnt_reg;
    tick_next = tick_reg;
    cmd_next = cmd_reg;
    wen_next = wen_reg;
    if (lock_reg != LK_IDLE) begin
      if (tick_reg == TICK_LAST) begin
        tick_next = 4'h0;
        if (dcnt_reg == 7'h00) begin
          lock_next = LK_IDLE;
        end else begin
          dcnt_next = dcnt_reg - 7'h01;
        end
      end else begin
        tick_next = tick_reg + 4'h1;
      end
    end
    if (cmd_wr) begin
      cmd_next = wbyte;
      if (wbyte == KEY_ARM) begin
        lock_next = LK_ARMED;
        dcnt_next = CNT_LOAD;
        tick_next = 4'h0;
      end else if (wbyte == KEY_OPEN && lock_reg == LK_ARMED) begin
        lock_next = LK_OPEN;
        dcnt_next = CNT_LOAD;
        tick_next = 4'h0;
      end else if ({1'b0, wbyte} >= {1'b0, PAGE_LIMIT}) begin
        // A wrong key ends any attempt in progress
        lock_next = LK_IDLE;
      end
    end
    // Enable stays until cleared; clearing needs no key
    if (stat_wr) begin
      if (!pwdata_i[STAT_WEN_BIT]) begin
        wen_next = 1'b0;
      end else if (lock_reg == LK_OPEN) begin
        wen_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lock_reg <= LK_IDLE;
      dcnt_reg <= 7'h00;
      tick_reg <= 4'h0;
      cmd_reg <= CMD_RESET;
      wen_reg <= 1'b0;
    end else begin
      lock_reg <= lock_next;
      dcnt_reg <= dcnt_next;
      tick_reg <= tick_next;
      cmd_reg <= cmd_next;
      wen_reg <= wen_next;
    end
  end

  // Self-timed write and erase; no power-fail flag is kept, on purpose
  always_comb begin
    op_next = op_reg;
    opcnt_next = opcnt_reg;
    faddr_next = faddr_reg;
    fdata_next = fdata_reg;
    unique case (op_reg)
      OP_IDLE: begin
        if (erase_go) begin
          op_next = OP_ERASE;
          opcnt_next = ERASE_LAST;
          faddr_next = 15'(wbyte[5:0]) << PAGE_SHIFT;
        end else if (write_go) begin
          op_next = OP_WRITE;
          opcnt_next = WRITE_LAST;
          faddr_next = core_addr_i;
          fdata_next = core_wdata_i;
        end
      end
      OP_WRITE: begin
        // A started byte write always finishes
        if (opcnt_reg == '0) begin
          op_next = OP_IDLE;
        end else begin
          opcnt_next = opcnt_reg - OP_CNT_W'(1);
        end
      end
      OP_ERASE: begin
        if (pf_reg || opcnt_reg == '0) begin
          op_next = OP_IDLE;
          opcnt_next = '0;
        end else begin
          opcnt_next = opcnt_reg - OP_CNT_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      op_reg <= OP_IDLE;
      opcnt_reg <= '0;
      faddr_reg <= 15'h0000;
      fdata_reg <= 8'h00;
    end else begin
      op_reg <= op_next;
      opcnt_reg <= opcnt_next;
      faddr_reg <= faddr_next;
      fdata_reg <= fdata_next;
    end
  end

  assign flash_prog_o = (op_reg == OP_WRITE);
  assign flash_erase_o = (op_reg == OP_ERASE);
  assign flash_addr_o = faddr_reg;
  assign flash_wdata_o = fdata_reg;

  // Protected-start flag and start address, recomputed every cycle once the scan ends
  logic stp_reg;
  logic stp_next;
  logic [15:0] start_reg;
  logic [15:0] start_next;

  always_comb begin
    stp_next = stp_reg;
    start_next = start_reg;
    if (scan_done) begin
      stp_next = data_area_enable_i && scan_odd;
      start_next = stp_next ? 16'(unprotected_page_count_i) << PAGE_SHIFT : BOOT_ZERO;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stp_reg <= 1'b0;
      start_reg <= BOOT_ZERO;
    end else begin
      stp_reg <= stp_next;
      start_reg <= start_next;
    end
  end

  assign core_start_addr_o = start_reg;
  assign core_vector_base_o = IRQ_VECTOR_BASE;

  // Core waits for the boot scan, and for any operation while fetching flash
  assign core_stall_o = !scan_done || (busy && core_fetch_flash_i);
  assign core_irq_hold_o = core_stall_o;

  // Read mux; data held in a flop so prdata changes only on clock edges
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (psel_i && !penable_i && !pwrite_i) begin
      unique case (paddr_i)
        ADDR_CMD: rdata_next = {24'h000000, cmd_reg};
        ADDR_STAT: begin
          rdata_next[STAT_STP_BIT] = stp_reg;
          rdata_next[STAT_WEN_BIT] = wen_reg;
          rdata_next[STAT_BUSY_BIT] = busy;
        end
        ADDR_PROT: begin
          rdata_next[PROT_DATA_AREA_ENABLE_BIT] = data_area_enable_i;
          rdata_next[6:0] = unprotected_page_count_i;
        end
        ADDR_BOOT: rdata_next = {16'h0000, start_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end else if (apb_rd) begin
      rdata_next = rdata_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign prdata_o = rdata_reg;
endmodule

/* File: src/mfw_pkg.sv */
// Constants and types shared by the flash write and erase controller
package mfw_pkg;
  // APB register byte offsets
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_PROT = 8'h08;
  localparam logic [7:0] ADDR_BOOT = 8'h0c;
  // Status register bit positions
  localparam int STAT_STP_BIT = 6;
  localparam int STAT_WEN_BIT = 5;
  localparam int STAT_BUSY_BIT = 4;
  // Protect configuration register layout
  localparam int PROT_DATA_AREA_ENABLE_BIT = 7;
  // Reset values
  localparam logic [7:0] CMD_RESET = 8'h00;
  // Unlock keys and counter
  localparam logic [7:0] KEY_ARM = 8'haa;
  localparam logic [7:0] KEY_OPEN = 8'h55;
  localparam logic [6:0] CNT_LOAD = 7'h7f;
  localparam logic [7:0] PAGE_LIMIT = 8'h40;
  localparam logic [5:0] DATA_PAGE_FIRST = 6'h3e;
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int UNLOCK_WINDOW_NS = 8000;
  localparam int UNLOCK_STEPS = 128;
  localparam int TICK_CYC = (UNLOCK_WINDOW_NS * CLK_MHZ) / (1000 * UNLOCK_STEPS);
  localparam logic [3:0] TICK_LAST = 4'(TICK_CYC - 1);
  localparam int WRITE_CYC = 740;
  localparam int ERASE_CYC = 360000;
  localparam int OP_CNT_W = 19;
  // Boot parity scan and address map
  localparam int PAGE_SHIFT = 9;
  localparam logic [4:0] TOP_BYTES = 5'h10;
  localparam logic [14:0] TOP_BASE = 15'h7ff0;
  localparam logic [15:0] IRQ_VECTOR_BASE = 16'h0000;
  localparam logic [15:0] BOOT_ZERO = 16'h0000;

  typedef enum logic [1:0] {LK_IDLE, LK_ARMED, LK_OPEN} mfw_lock_t;
  typedef enum logic [1:0] {OP_IDLE, OP_WRITE, OP_ERASE} mfw_op_t;
endpackage

/* File: src/mfw_top_scan.sv */
// Reset-time parity scan of the highest sixteen data-area bytes
`timescale 1ns/100ps
module mfw_top_scan (
  input wire logic clk_i,
  input wire logic srst_i,
  output logic [14:0] rd_addr_o,
  input wire logic [7:0] rd_data_i,
  output logic done_o,
  output logic odd_o
);
  import mfw_pkg::*;

  logic [4:0] idx_reg;
  logic [4:0] idx_next;
  logic pend_reg;
  logic pend_next;
  logic par_reg;
  logic par_next;
  logic done_reg;
  logic done_next;

  // Issue one address a cycle; the array answers one cycle later
  always_comb begin
    idx_next = idx_reg;
    pend_next = 1'b0;
    par_next = par_reg;
    done_next = done_reg;
    if (!done_reg) begin
      if (idx_reg < TOP_BYTES) begin
        idx_next = idx_reg + 5'h01;
        pend_next = 1'b1;
      end
      if (pend_reg) begin
        par_next = par_reg ^ (^rd_data_i);
      end
      if (idx_reg == TOP_BYTES && pend_reg) begin
        done_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      idx_reg <= 5'h00;
      pend_reg <= 1'b0;
      par_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      idx_reg <= idx_next;
      pend_reg <= pend_next;
      par_reg <= par_next;
      done_reg <= done_next;
    end
  end

  assign rd_addr_o = TOP_BASE | {11'h000, idx_reg[3:0]};
  assign done_o = done_reg;
  assign odd_o = par_reg;
endmodule

/* File: dv/mfw_ctrl_sva.sv */
// Port-level checker for the flash write and erase controller
`timescale 1ns/100ps
module mfw_ctrl_sva #(
  parameter int ERASE_CYCLES = 360000
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic power_fail_i,
  input wire logic [14:0] core_addr_i,
  input wire logic [7:0] core_wdata_i,
  input wire logic core_fetch_flash_i,
  input wire logic core_stall_o,
  input wire logic core_irq_hold_o,
  input wire logic [15:0] core_start_addr_o,
  input wire logic [15:0] core_vector_base_o,
  input wire logic [6:0] unprotected_page_count_i,
  input wire logic data_area_enable_i,
  input wire logic flash_prog_o,
  input wire logic flash_erase_o,
  input wire logic [14:0] flash_addr_o,
  input wire logic [7:0] flash_wdata_o
);
  import mfw_pkg::*;
  logic [19:0] pcnt_reg, pcnt_next, ecnt_reg, ecnt_next;
  // Length of the running write and erase, cleared when idle
  always_comb begin
    pcnt_next = flash_prog_o ? pcnt_reg + 20'h1 : 20'h0;
    ecnt_next = flash_erase_o ? ecnt_reg + 20'h1 : 20'h0;
  end
  always_ff @(posedge clk_i) begin
    pcnt_reg <= srst_i ? 20'h0 : pcnt_next;
    ecnt_reg <= srst_i ? 20'h0 : ecnt_next;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Power fail needs two sync flops before it acts, hence the margins
  sequence s_pf_held;
    power_fail_i [*4];
  endsequence
  sequence s_erase_hit;
    flash_erase_o && power_fail_i;
  endsequence
  property p_stall_op;
    (flash_prog_o || flash_erase_o) && core_fetch_flash_i |-> core_stall_o;
  endproperty
  a_stall_op: assert property (p_stall_op) else $error("core runs during flash op");
  property p_irq_hold;
    core_irq_hold_o == core_stall_o;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq hold differs from stall");
  property p_vector;
    core_vector_base_o == 16'h0000;
  endproperty
  a_vector: assert property (p_vector) else $error("vector base moved");
  property p_write_len;
    $fell(flash_prog_o) |-> pcnt_reg == WRITE_CYC;
  endproperty
  a_write_len: assert property (p_write_len) else $error("byte write length wrong");
  property p_erase_len;
    ecnt_reg <= ERASE_CYCLES;
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase runs too long");
  property p_pf_new;
    s_pf_held |=> !$rose(flash_erase_o) && !$rose(flash_prog_o);
  endproperty
  a_pf_new: assert property (p_pf_new) else $error("op started in power fail");
  property p_pf_abort;
    s_erase_hit |-> ##[1:5] !flash_erase_o;
  endproperty
  a_pf_abort: assert property (p_pf_abort) else $error("erase not aborted");
  property p_write_addr;
    $rose(flash_prog_o) |-> flash_addr_o == $past(core_addr_i) &&
      flash_wdata_o == $past(core_wdata_i);
  endproperty
  a_write_addr: assert property (p_write_addr) else $error("write address or data wrong");
  property p_boot;
    core_start_addr_o == 16'h0000 || core_start_addr_o == {unprotected_page_count_i, 9'h000};
  endproperty
  a_boot: assert property (p_boot) else $error("start address not allowed");
  property p_boot_data_area_enable;
    !data_area_enable_i && $fell(core_stall_o) |=> core_start_addr_o == 16'h0000;
  endproperty
  a_boot_data_area_enable: assert property (p_boot_data_area_enable) else $error("start moved without data area");
endmodule

bind mfw_ctrl mfw_ctrl_sva #(.ERASE_CYCLES(ERASE_CYCLES)) u_sva (
  .clk_i(clk_i), .srst_i(srst_i), .power_fail_i(power_fail_i), .core_addr_i(core_addr_i),
  .core_wdata_i(core_wdata_i), .core_fetch_flash_i(core_fetch_flash_i),
  .core_stall_o(core_stall_o), .core_irq_hold_o(core_irq_hold_o),
  .core_start_addr_o(core_start_addr_o), .core_vector_base_o(core_vector_base_o),
  .unprotected_page_count_i(unprotected_page_count_i),
  .data_area_enable_i(data_area_enable_i), .flash_prog_o(flash_prog_o),
  .flash_erase_o(flash_erase_o), .flash_addr_o(flash_addr_o), .flash_wdata_o(flash_wdata_o)
);

/* File: dv/mfw_flash_model.sv */
// Behavioural flash array behind the controller's flash port
`timescale 1ns/100ps
module mfw_flash_model (
  input wire logic clk_i,
  input wire logic [14:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  input wire logic prog_i,
  input wire logic [14:0] addr_i,
  input wire logic [7:0] wdata_i
);
  logic [7:0] mem [0:32767];
  // Erased array; one top byte of 0xfe leaves an odd count of ones on top
  initial begin
    for (int i = 0; i < 32768; i++)
      mem[i] = 8'hff;
    mem[15'h7ff0] = 8'hfe;
  end
  // Read answers the previous cycle's address, no faster than real flash
  always @(posedge clk_i) begin
    rd_data_o <= mem[rd_addr_i];
    if (prog_i)
      mem[addr_i] <= wdata_i;
  end
endmodule

/* File: dv/mfw_ctrl_tb.sv */
// Directed bench for the flash write and erase controller
`timescale 1ns/100ps
module mfw_ctrl_tb;
  import mfw_pkg::*;
  localparam int ERC = 64;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic core_wr_i = 1'b0;
  logic [14:0] core_addr_i = 15'h0;
  logic [7:0] core_wdata_i = 8'h00;
  logic core_fetch_flash_i = 1'b1;
  logic power_fail_i = 1'b0;
  logic [6:0] unprotected_page_count_i = 7'h10;
  logic data_area_enable_i = 1'b1;
  logic pready_o, pslverr_o, core_stall_o, core_irq_hold_o, flash_prog_o, flash_erase_o;
  logic [15:0] core_start_addr_o, core_vector_base_o;
  logic [14:0] flash_addr_o, flash_rd_addr_o;
  logic [7:0] flash_wdata_o, flash_rd_data_i;
  logic [31:0] prdata_o, r;
  logic err;
  int fail_count = 0;
  int checked = 0;
  int n;
  // 250 MHz, well above the flash minimum core clock
  always #2 clk_i = ~clk_i;
  mfw_ctrl #(.ERASE_CYCLES(ERC)) dut (
    .clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .core_wr_i(core_wr_i),
    .core_addr_i(core_addr_i), .core_wdata_i(core_wdata_i),
    .core_fetch_flash_i(core_fetch_flash_i), .core_stall_o(core_stall_o),
    .core_irq_hold_o(core_irq_hold_o), .core_start_addr_o(core_start_addr_o),
    .core_vector_base_o(core_vector_base_o), .power_fail_i(power_fail_i),
    .unprotected_page_count_i(unprotected_page_count_i),
    .data_area_enable_i(data_area_enable_i), .flash_prog_o(flash_prog_o),
    .flash_erase_o(flash_erase_o), .flash_addr_o(flash_addr_o),
    .flash_wdata_o(flash_wdata_o), .flash_rd_addr_o(flash_rd_addr_o),
    .flash_rd_data_i(flash_rd_data_i)
  );
  mfw_flash_model u_flash (
    .clk_i(clk_i), .rd_addr_i(flash_rd_addr_o), .rd_data_o(flash_rd_data_i),
    .prog_i(flash_prog_o), .addr_i(flash_addr_o), .wdata_i(flash_wdata_o)
  );
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One APB transfer; data and error taken at the pready edge only
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1)
      @(posedge clk_i);
    r = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  // Scan needs 17 edges after release before the core may run
  task automatic rst();
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (20) @(posedge clk_i);
  endtask
  task automatic pf(input logic v);
    @(posedge clk_i);
    power_fail_i <= v;
    repeat (4) @(posedge clk_i);
  endtask
  // Key pair with a gap after each key, then try to set write enable
  task automatic unl(input int g, input logic [31:0] e);
    wr(ADDR_CMD, {24'h0, KEY_ARM});
    repeat (g) @(posedge clk_i);
    wr(ADDR_CMD, {24'h0, KEY_OPEN});
    repeat (g) @(posedge clk_i);
    wr(ADDR_STAT, 32'h20);
    rd(ADDR_STAT, e);
  endtask
  // Core byte write or erase command; n counts busy cycles, 0 when refused
  task automatic op(input logic w, input logic [14:0] a, input logic [7:0] d, input int e);
    n = 0;
    if (w) begin
      @(posedge clk_i);
      core_addr_i <= a;
      core_wdata_i <= d;
      core_wr_i <= 1'b1;
      @(posedge clk_i);
      core_wr_i <= 1'b0;
    end else begin
      wr(ADDR_CMD, {24'h0, d});
    end
    for (int k = 0; k < 4; k++) begin
      @(negedge clk_i);
      if ((flash_prog_o | flash_erase_o) === 1'b1)
        break;
    end
    // Target address and core hold, looked at once the operation runs
    if ((flash_prog_o | flash_erase_o) === 1'b1) begin
      chk(flash_addr_o, w ? a : {d[5:0], 9'h000});
      chk({core_irq_hold_o, core_stall_o}, {2{core_fetch_flash_i}});
    end
    while ((flash_prog_o | flash_erase_o) === 1'b1) begin
      n++;
      @(negedge clk_i);
    end
    if (e >= 0)
      chk(n, e);
  endtask
  task automatic wrap_up();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence
  initial begin
    rst();
    chk(core_start_addr_o, 32'h2000);
    chk(core_vector_base_o, 32'h0);
    rd(ADDR_BOOT, 32'h2000);
    rd(ADDR_STAT, 32'h40);
    rd(ADDR_PROT, 32'h90);
    rd(8'h10, 32'h0);
    chk(err, 1'b1);
    wr(ADDR_STAT, 32'h20);
    rd(ADDR_STAT, 32'h40);
    // A non-key byte of 0x40 or more between the keys cancels the attempt
    wr(ADDR_CMD, {24'h0, KEY_ARM});
    wr(ADDR_CMD, 32'h80);
    wr(ADDR_CMD, {24'h0, KEY_OPEN});
    wr(ADDR_STAT, 32'h20);
    rd(ADDR_STAT, 32'h40);
    op(1'b1, 15'h0100, 8'h5a, 0);
    unl(2000, 32'h40);
    unl(1800, 32'h60);
    op(1'b1, 15'h0100, 8'h5a, 740);
    op(1'b1, 15'h0101, 8'ha5, 740);
    chk({u_flash.mem[15'h0101], u_flash.mem[15'h0100]}, 32'ha55a);
    op(1'b1, 15'h2800, 8'h00, 0);
    op(1'b1, 15'h7c10, 8'h00, 740);
    op(1'b0, 15'h0, 8'h05, ERC);
    op(1'b0, 15'h0, 8'h20, 0);
    op(1'b0, 15'h0, 8'h3f, ERC);
    rd(ADDR_CMD, 32'h3f);
    @(posedge clk_i);
    core_fetch_flash_i <= 1'b0;
    fork
      op(1'b1, 15'h0102, 8'h3c, 740);
      begin
        repeat (10) @(posedge clk_i);
        rd(ADDR_STAT, 32'h70);
        chk(core_stall_o, 1'b0);
      end
    join
    pf(1'b1);
    op(1'b1, 15'h0104, 8'h22, 0);
    op(1'b0, 15'h0, 8'h05, 0);
    pf(1'b0);
    fork
      op(1'b0, 15'h0, 8'h05, -1);
      begin
        repeat (20) @(posedge clk_i);
        power_fail_i <= 1'b1;
      end
    join
    chk((n > 0) && (n < ERC), 1'b1);
    pf(1'b0);
    fork
      op(1'b1, 15'h0103, 8'h11, 740);
      begin
        repeat (50) @(posedge clk_i);
        power_fail_i <= 1'b1;
      end
    join
    pf(1'b0);
    rd(ADDR_STAT, 32'h60);
    wr(ADDR_STAT, 32'h0);
    rd(ADDR_STAT, 32'h40);
    op(1'b1, 15'h0104, 8'h22, 0);
    @(posedge clk_i);
    data_area_enable_i <= 1'b0;
    rst();
    chk(core_start_addr_o, 32'h0);
    rd(ADDR_STAT, 32'h0);
    wrap_up();
  end
  // Hang guard, far beyond the expected run of about 12000 cycles
  initial begin
    repeat (60000) @(posedge clk_i);
    fail_count++;
    wrap_up();
  end
endmodule
